// *** verilog/tcr_pkg.sv ***
/*
 * Package of the tuner clock, divider and status register bank:
 * register offsets, reset values, field positions and carrier types.
 * Assumes one device clock and a protocol engine on that same clock.
 */
// Notes on behaviour
// - Divider code zero disables output; else divides.
// - Power-down stops all but bus, keeps registers.
// - Standby stops signal path only; clock output keeps running.
// - Bit zero set disables the Q channel.
// - Integer divider joins high byte and low five.
// - Status bits 4..3 show charge-pump code.
// - Power flag set at power-up, cleared by read STOP.
// - Success bit only when autoselect enabled and succeeded.
// - Idle bit low while autoselect runs.
// - Charge-pump code maps 1.5 to 3 mA.
// - Read returns status one then two, MSB first.
package tcr_pkg;

    // Register offsets on the internal write port
    localparam logic [7:0] TCR_ADDR_CLKOUT = 8'h00;
    localparam logic [7:0] TCR_ADDR_RDIV = 8'h01;
    localparam logic [7:0] TCR_ADDR_NHI = 8'h02;
    localparam logic [7:0] TCR_ADDR_NLO = 8'h03;

    // Reset values (recommended defaults)
    localparam logic [7:0] TCR_RST_CLKOUT = 8'h08;
    localparam logic [7:0] TCR_RST_RDIV = 8'h38;
    localparam logic [7:0] TCR_RST_NHI = 8'h53;
    localparam logic [7:0] TCR_RST_NLO = 8'hF8;

    // Field positions in the clock-out register
    localparam int TCR_XD_MSB = 7;
    localparam int TCR_XD_LSB = 3;
    localparam int TCR_SOFTWARE_POWER_DOWN_BIT = 2;
    localparam int TCR_SOFTWARE_STANDBY_BIT = 1;
    localparam int TCR_QUADRATURE_OUTPUT_DISABLE_BIT = 0;

    // Writable field mask of the low integer-divider register
    localparam logic [7:0] TCR_NLO_MASK = 8'hF8;

    // Charge-pump current codes
    typedef enum logic [1:0] {
        TCR_CP_1P5MA = 2'h0,
        TCR_CP_2MA = 2'h1,
        TCR_CP_2P5MA = 2'h2,
        TCR_CP_3MA = 2'h3
    } tcr_cp_t;

    // Register write request from the protocol engine
    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } tcr_wr_t;

    // Live state of the synthesizer and autoselect engine
    typedef struct packed {
        tcr_cp_t cp_code;
        logic vas_success;
        logic vas_busy;
        logic [1:0] vco_sel;
        logic [2:0] sub_band;
        logic [2:0] adc;
    } tcr_stat_t;

endpackage

// *** verilog/tcr_regs.sv ***
/*
 * Register bank of the tuner: divided crystal clock tick, power-down,
 * standby and Q controls, reference and integer dividers, and the two
 * status bytes shifted out MSB first on read.
 * Assumes the protocol engine runs on ref_clk and drives wr, rd_load,
 * rd_shift and rd_stop; synth_stat comes from analog logic, asynchronous.
 */
`timescale 1ns/1ps
module tcr_regs (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Protocol engine side
    input wire tcr_pkg::tcr_wr_t wr,
    input wire logic rd_load,
    input wire logic rd_shift,
    input wire logic rd_stop,
    output logic rd_bit,
    // Synthesizer side
    input wire tcr_pkg::tcr_stat_t synth_stat,
    input wire logic vco_autoselect_enable,
    // Controls
    output logic divided_crystal_clock_output,
    output logic clock_out_buffer_enable,
    output logic software_power_down,
    output logic software_standby,
    output logic quadrature_output_disable,
    output logic signal_path_enable,
    output logic [7:0] pll_reference_divider,
    output logic [12:0] pll_integer_divider,
    output logic power_cycled_flag
);

    logic [7:0] clkout_q, clkout_d;
    logic [7:0] rdiv_q, rdiv_d;
    logic [7:0] nhi_q, nhi_d;
    logic [7:0] nlo_q, nlo_d;
    logic pwr_q, pwr_d;
    logic path_q, path_d;
    logic bufen_q, bufen_d;
    logic [4:0] cnt_q, cnt_d;
    logic tick_q, tick_d;
    logic [15:0] shift_q, shift_d;
    tcr_pkg::tcr_stat_t sync1_q, sync2_q;
    logic [4:0] xd;
    logic [7:0] status1, status2;

    assign xd = clkout_q[tcr_pkg::TCR_XD_MSB:tcr_pkg::TCR_XD_LSB];

    // Two-stage synchroniser for the analog-side status
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else if (clk_en) begin
            sync1_q <= synth_stat;
            sync2_q <= sync1_q;
        end
    end

    // Status byte assembly
    always_comb begin
        status1 = 8'h00;
        status1[4:3] = sync2_q.cp_code;
        status1[2] = pwr_q;
        status1[1] = vco_autoselect_enable & sync2_q.vas_success;
        status1[0] = ~sync2_q.vas_busy;
        status2 = {sync2_q.vco_sel, sync2_q.sub_band, sync2_q.adc};
    end

    // Register writes, power flag and read shifter
    always_comb begin
        clkout_d = clkout_q;
        rdiv_d = rdiv_q;
        nhi_d = nhi_q;
        nlo_d = nlo_q;
        pwr_d = pwr_q;
        shift_d = shift_q;
        if (wr.en) begin
            if (wr.addr == tcr_pkg::TCR_ADDR_CLKOUT) begin
                clkout_d = wr.data;
            end else if (wr.addr == tcr_pkg::TCR_ADDR_RDIV) begin
                rdiv_d = wr.data;
            end else if (wr.addr == tcr_pkg::TCR_ADDR_NHI) begin
                nhi_d = wr.data;
            end else if (wr.addr == tcr_pkg::TCR_ADDR_NLO) begin
                nlo_d = wr.data & tcr_pkg::TCR_NLO_MASK;
            end
        end
        if (rd_stop) begin
            pwr_d = 1'b0;
        end
        // byte one then two, MSB first
        if (rd_load) begin
            shift_d = {status1, status2};
        end else if (rd_shift) begin
            shift_d = {shift_q[14:0], 1'b0};
        end
    end

    // Clock output divider and enables
    always_comb begin
        cnt_d = 5'h00;
        tick_d = 1'b0;
        bufen_d = (xd != 5'h00) && !clkout_q[tcr_pkg::TCR_SOFTWARE_POWER_DOWN_BIT];
        path_d = !clkout_q[tcr_pkg::TCR_SOFTWARE_POWER_DOWN_BIT] && !clkout_q[tcr_pkg::TCR_SOFTWARE_STANDBY_BIT];
        if (bufen_d) begin
            if (cnt_q >= xd - 5'h01) begin
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 5'h01;
            end
        end
    end

    // State registers
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            clkout_q <= tcr_pkg::TCR_RST_CLKOUT;
            rdiv_q <= tcr_pkg::TCR_RST_RDIV;
            nhi_q <= tcr_pkg::TCR_RST_NHI;
            nlo_q <= tcr_pkg::TCR_RST_NLO;
            pwr_q <= 1'b1;
            path_q <= 1'b0;
            bufen_q <= 1'b0;
            cnt_q <= 5'h00;
            tick_q <= 1'b0;
            shift_q <= 16'h0000;
        end else if (clk_en) begin
            clkout_q <= clkout_d;
            rdiv_q <= rdiv_d;
            nhi_q <= nhi_d;
            nlo_q <= nlo_d;
            pwr_q <= pwr_d;
            path_q <= path_d;
            bufen_q <= bufen_d;
            cnt_q <= cnt_d;
            tick_q <= tick_d;
            shift_q <= shift_d;
        end
    end

    // Outputs, each a flip-flop bit
    assign rd_bit = shift_q[15];
    assign divided_crystal_clock_output = tick_q;
    assign clock_out_buffer_enable = bufen_q;
    assign software_power_down = clkout_q[tcr_pkg::TCR_SOFTWARE_POWER_DOWN_BIT];
    assign software_standby = clkout_q[tcr_pkg::TCR_SOFTWARE_STANDBY_BIT];
    assign quadrature_output_disable = clkout_q[tcr_pkg::TCR_QUADRATURE_OUTPUT_DISABLE_BIT];
    assign signal_path_enable = path_q;
    assign pll_reference_divider = rdiv_q;
    assign pll_integer_divider = {nhi_q, nlo_q[7:3]};
    assign power_cycled_flag = pwr_q;

    // Checks
    property p_xd_zero_off;
        @(posedge ref_clk) disable iff (!rst_b)
        (clk_en && xd == 5'h00) |=> (!tick_q && !bufen_q);
    endproperty
    a_xd_zero_off: assert property (p_xd_zero_off) else $error("tick with divider off");

    property p_div3;
        @(posedge ref_clk) disable iff (!rst_b)
        (tick_q && xd == 5'h03 && !software_power_down && clk_en && !wr.en) ##1
        (clk_en && !wr.en) [*2] |-> ((!tick_q && !$past(tick_q)) ##1 tick_q);
    endproperty
    a_div3: assert property (p_div3) else $error("divide by three wrong");

    property p_software_power_down;
        @(posedge ref_clk) disable iff (!rst_b)
        (clk_en && software_power_down) |=> (!signal_path_enable && !tick_q);
    endproperty
    a_software_power_down: assert property (p_software_power_down) else $error("active in power-down");

    property p_software_standby;
        @(posedge ref_clk) disable iff (!rst_b)
        (clk_en && software_standby && !software_power_down && xd != 5'h00)
        |=> (!signal_path_enable && clock_out_buffer_enable);
    endproperty
    a_software_standby: assert property (p_software_standby) else $error("standby gating wrong");

    property p_quadrature_output_disable;
        @(posedge ref_clk) disable iff (!rst_b)
        (clk_en && wr.en && wr.addr == tcr_pkg::TCR_ADDR_CLKOUT)
        |=> (quadrature_output_disable == $past(wr.data[0]));
    endproperty
    a_quadrature_output_disable: assert property (p_quadrature_output_disable) else $error("Q control not written");

    property p_nlo;
        @(posedge ref_clk) disable iff (!rst_b)
        (clk_en && wr.en && wr.addr == tcr_pkg::TCR_ADDR_NLO)
        |=> (pll_integer_divider[4:0] == $past(wr.data[7:3]) && nlo_q[2:0] == 3'h0);
    endproperty
    a_nlo: assert property (p_nlo) else $error("low divider field wrong");

    property p_load;
        @(posedge ref_clk) disable iff (!rst_b)
        (clk_en && rd_load) |=> (shift_q[15:13] == 3'h0 && shift_q[11] == $past(status1[3]));
    endproperty
    a_load: assert property (p_load) else $error("status byte load wrong");

    property p_pwr_clr;
        @(posedge ref_clk) disable iff (!rst_b)
        (clk_en && rd_stop) |=> !power_cycled_flag;
    endproperty
    a_pwr_clr: assert property (p_pwr_clr) else $error("power flag not cleared");

    property p_vco_autoselect_success;
        @(posedge ref_clk) disable iff (!rst_b)
        (clk_en && rd_load && !vco_autoselect_enable) |=> !shift_q[9];
    endproperty
    a_vco_autoselect_success: assert property (p_vco_autoselect_success) else $error("success shown while disabled");

endmodule // tcr_regs

// *** sim/tcr_host_model.sv ***
/*
 * Host-side model of the protocol engine: byte writes and status reads.
 * Assumes the bench calls its tasks; drives only at falling edges.
 */
`timescale 1ns/1ps
module tcr_host_model (
    // Clock
    input wire logic ref_clk,
    // Engine strobes
    output tcr_pkg::tcr_wr_t wr,
    output logic rd_load,
    output logic rd_shift,
    output logic rd_stop,
    // Serial data back
    input wire logic rd_bit
);
    // Idle strobes
    initial begin
        wr = '0;
        rd_load = 1'b0;
        rd_shift = 1'b0;
        rd_stop = 1'b0;
    end
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        wr = '{en: 1'b1, addr: a, data: d};
        @(negedge ref_clk);
        wr = '{en: 1'b0, addr: ~a, data: ~d}; // Stale bus shows junk
    endtask
    task automatic get(output logic [15:0] v);
        @(negedge ref_clk);
        rd_load = 1'b1;
        for (int i = 0; i < 16; i++) begin
            @(negedge ref_clk);
            rd_load = 1'b0;
            v = {v[14:0], rd_bit};
            rd_shift = (i < 15);
        end
    endtask
    task automatic stop();
        @(negedge ref_clk);
        rd_stop = 1'b1;
        @(negedge ref_clk);
        rd_stop = 1'b0;
    endtask
endmodule // tcr_host_model

// *** sim/tuner_clock_pll_status_regs_tb_top.sv ***
/*
 * Bench of the tuner register bank: random writes, divider ticks, reads.
 * Assumes a 200 MHz ref_clk and synchronous active-low rst_b.
 */
`timescale 1ns/1ps
module tuner_clock_pll_status_regs_tb_top;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    logic vas_en = 1'b1;
    tcr_pkg::tcr_stat_t stat = '0;
    tcr_pkg::tcr_wr_t wr;
    logic rd_load, rd_shift, rd_stop, rd_bit, tick, buf_en, pd, sb, qd, spe, pf;
    logic [7:0] rdiv;
    logic [12:0] ndiv;
    logic [15:0] v;
    logic [7:0] d;
    logic [7:0] r;
    logic [12:0] nv;
    int bad_count = 0;
    int checked = 0;
    int n;
    // 200 MHz clock
    always #2.5 ref_clk = ~ref_clk;
    // Far side and design
    tcr_host_model h (.ref_clk(ref_clk), .wr(wr), .rd_load(rd_load),
        .rd_shift(rd_shift), .rd_stop(rd_stop), .rd_bit(rd_bit));
    tcr_regs DUT (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .wr(wr),
        .rd_load(rd_load), .rd_shift(rd_shift), .rd_stop(rd_stop), .rd_bit(rd_bit),
        .synth_stat(stat), .vco_autoselect_enable(vas_en),
        .divided_crystal_clock_output(tick), .clock_out_buffer_enable(buf_en),
        .software_power_down(pd), .software_standby(sb),
        .quadrature_output_disable(qd), .signal_path_enable(spe),
        .pll_reference_divider(rdiv), .pll_integer_divider(ndiv),
        .power_cycled_flag(pf));
    // Expected read-out of both status bytes
    function automatic logic [15:0] st_exp(tcr_pkg::tcr_stat_t s, logic e, logic p);
        return {3'h0, s.cp_code, p, e & s.vas_success, ~s.vas_busy,
            s.vco_sel, s.sub_band, s.adc};
    endfunction
    // Value compare
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Tick count over four periods
    task automatic ticks(input logic [4:0] c);
        h.put(8'h00, {c, 3'b000});
        repeat (c + 4) @(negedge ref_clk);
        n = 0;
        repeat (c == 0 ? 40 : 4 * c) begin
            @(negedge ref_clk);
            n += tick;
        end
        chk("ticks", (c == 0) ? 16'h0000 : 16'h0004, 16'(n));
        chk("bufen", {15'h0, c != 0}, {15'h0, buf_en});
    endtask
    // Verdict
    task automatic complete_run();
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #100000;
        bad_count++;
        complete_run();
    end
    // Main sequence
    initial begin
        void'($urandom(32'hF7F450A1));
        repeat (8) @(negedge ref_clk);
        rst_b = 1'b1;
        chk("rdiv", 16'h0038, {8'h00, rdiv});
        chk("ndiv", 16'h0A7F, {3'h0, ndiv});
        chk("flags", 16'h0001, {12'h0, pd, sb, qd, pf});
        // Default divide-by-one runs right after reset
        repeat (2) @(negedge ref_clk);
        chk("bufen", 16'h0001, {15'h0, buf_en});
        chk("tick", 16'h0001, {15'h0, tick});
        chk("path", 16'h0001, {15'h0, spe});
        $display("reset test done");
        repeat (24) begin
            d = 8'($urandom);
            r = 8'($urandom_range(182, 22));
            nv = 13'($urandom_range(5374, 829));
            h.put(8'h01, r);
            h.put(8'h02, nv[12:5]);
            h.put(8'h03, {nv[4:0], d[2:0]});
            h.put(d | 8'h04, ~d);
            chk("rdiv", {8'h00, r}, {8'h00, rdiv});
            chk("ndiv", {3'h0, nv}, {3'h0, ndiv});
            h.put(8'h00, d);
            chk("ctrl", {13'h0, d[2:0]}, {13'h0, pd, sb, qd});
            @(negedge ref_clk);
            chk("path", {15'h0, ~(d[2] | d[1])}, {15'h0, spe});
            clk_en = 1'b0;
            h.put(8'h01, (r == 8'h38) ? 8'h39 : 8'h38);
            clk_en = 1'b1;
            chk("frozen", {8'h00, r}, {8'h00, rdiv});
        end
        $display("write test done");
        for (int i = 0; i < 8; i++) begin
            ticks(i < 2 ? 5'(i) : (i == 2 ? 5'h1F :
                (i == 3 ? 5'h03 : 5'($urandom_range(2, 30)))));
        end
        $display("divider test done");
        for (int i = 0; i < 8; i++) begin
            stat = tcr_pkg::tcr_stat_t'(13'($urandom));
            stat.cp_code = tcr_pkg::tcr_cp_t'(i[1:0]);
            vas_en = i[2];
            if (i == 4) begin
                h.stop();
                chk("pflag", 16'h0000, {15'h0, pf});
            end
            repeat (5) @(negedge ref_clk);
            h.get(v);
            chk("status", st_exp(stat, vas_en, i < 4), v);
        end
        $display("status test done");
        complete_run();
    end
endmodule // tuner_clock_pll_status_regs_tb_top
